/* shared/bridge_cfg_pkg.sv */
`default_nettype none
package bridge_cfg_pkg;
	// command codes recognised by this decoder
	localparam logic [7:0] CMD_WRITE_CONFIG = 8'hD2;
	localparam logic [7:0] CMD_ADJUST_PORT  = 8'hC3;
	// control byte fields
	localparam int SEL_MSB  = 7;
	localparam int SEL_LSB  = 5;
	localparam int OD_BIT   = 4;
	localparam int CODE_MSB = 3;
	// parameter selector values
	localparam logic [2:0] SEL_RSTL = 3'h0;
	localparam logic [2:0] SEL_MSP  = 3'h1;
	localparam logic [2:0] SEL_W0L  = 3'h2;
	localparam logic [2:0] SEL_REC  = 3'h3;
	localparam logic [2:0] SEL_RWPU = 3'h4;
	// storage slots: 0..5 timed pairs, then recovery, then pullup
	localparam logic [2:0] SLOT_REC  = 3'h6;
	localparam logic [2:0] SLOT_RWPU = 3'h7;
	localparam int NUM_SLOTS = 8;
	localparam int PARAM_W   = 4;
	// device configuration bit positions
	localparam int CFG_APU_BIT = 0;
	localparam int CFG_PDN_BIT = 1;
	localparam int CFG_SPU_BIT = 2;
	localparam int CFG_OWS_BIT = 3;
	localparam logic [3:0] CFG_RESET     = 4'h0;
	localparam logic       RSTFLAG_RESET = 1'b1;
	// wishbone byte offsets
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_DEVCFG  = 8'h08;
	localparam logic [7:0] ADDR_PORTCFG = 8'h0C;
	localparam int CTRL_DEVRST_BIT = 0;
	localparam int ST_RSTFLAG_BIT  = 0;
	localparam int ST_BUSY_BIT     = 1;
	localparam int ST_PTR_LSB      = 4;
	// snapshot word crossing to the bus clock
	localparam int SNAP_W = 39;
	typedef enum logic [1:0] {
		PTR_STATUS,
		PTR_DATA,
		PTR_DEVCFG,
		PTR_PORTCFG
	} read_ptr_t;
	typedef enum logic [1:0] {
		CMD_IDLE,
		CMD_CFG_PARAM,
		CMD_ADJ_PARAM,
		CMD_IGNORE
	} cmd_state_t;
endpackage
`default_nettype wire

/* shared/snap_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the link-side settings word to the bus clock domain
interface snap_if #(
	parameter int W = 39
);
	logic [W-1:0] src_word;  // link-domain word, from flops
	logic [W-1:0] dst_word;  // bus-domain copy
	logic         dst_fresh; // pulse: dst_word just refreshed
	modport producer (
		output src_word,
		input  dst_word,
		input  dst_fresh
	);
	modport crossing (
		input  src_word,
		output dst_word,
		output dst_fresh
	);
endinterface
`default_nettype wire

/* core/snap_cross.sv */
`timescale 1ns/1ps
`default_nettype none
// two-phase toggle handshake moving a whole word between clocks
module snap_cross #(
	parameter int W = 39
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic link_clk,
	input  wire logic link_rst_n,
	snap_if.crossing  xf
);
	typedef struct packed {
		logic         req;   // request toggle
		logic         a1;    // ack synchroniser, first stage
		logic         a2;    // ack synchroniser, second stage
		logic [W-1:0] dst;   // captured word
		logic         fresh; // capture pulse
	} bus_st_t;
	typedef struct packed {
		logic         r1;    // request synchroniser, first stage
		logic         r2;    // request synchroniser, second stage
		logic         ack;   // acknowledge toggle
		logic [W-1:0] hold;  // word held stable for the bus side
	} lnk_st_t;
	bus_st_t bs;
	bus_st_t bn;
	lnk_st_t ls;
	lnk_st_t ln;

	// bus side: once ack matches req the held word is stable, take it
	always_comb begin
		bn = bs;
		bn.a1 = ls.ack;
		bn.a2 = bs.a1;
		bn.fresh = 1'b0;
		if (bs.a2 == bs.req) begin
			bn.dst = ls.hold;
			bn.fresh = 1'b1;
			bn.req = ~bs.req;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// req starts ahead of ack so the first word taken is a live
			// one, never the link side's cleared holding register
			bs <= '{req: 1'b1, default: '0};
		end else begin
			bs <= bn;
		end
	end

	// link side: a new request captures the word and answers
	always_comb begin
		ln = ls;
		ln.r1 = bs.req;
		ln.r2 = ls.r1;
		if (ls.r2 != ls.ack) begin
			ln.hold = xf.src_word;
			ln.ack = ls.r2;
		end
	end

	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			ls <= '0;
		end else begin
			ls <= ln;
		end
	end

	assign xf.dst_word  = bs.dst;
	assign xf.dst_fresh = bs.fresh;
endmodule
`default_nettype wire

/* core/bridge_config_commands.sv */
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - code D2h then configuration byte
// - store only if upper nibble inverts lower
// - config readback: zero upper nibble, settings low
// - busy at D2h: no ack, command ignored
// - config updates at ack rising SCL edge
// - config write points reader at config
// - config write clears reset flag, keeps ports
// - code C3h then control byte adjusts parameter
// - control byte: selector, overdrive flag, code
// - busy at C3h: no ack, command ignored
// - parameter stored at ack rising edge
// - port adjust points reader at port config
// - power-on or device reset restores defaults
// - selector map; flag ignored for 011, 100
// - flag picks overdrive or standard copy
module bridge_config_commands #(
	parameter logic [31:0] PARAM_DEFAULTS = 32'h6666_6666
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        bus_busy_flag,
	output logic             overdrive_speed_select,
	output logic             strong_pullup_enable,
	output logic             port_power_down,
	output logic             active_pullup_enable,
	output logic      [31:0] port_params,
	input  wire logic        link_clk,
	input  wire logic        frame_start,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	input  wire logic        ack_edge,
	input  wire logic        byte_read,
	output logic             ack_drive,
	output logic      [1:0]  read_ptr,
	output logic      [7:0]  read_byte
);
	// link-side state, clocked by the bridge's serial clock
	typedef struct packed {
		bridge_cfg_pkg::cmd_state_t st;   // command decoder state
		logic       por1;                 // reset synchroniser
		logic       por2;                 // reset synchroniser
		logic       busy1;                // busy synchroniser
		logic       busy2;                // busy synchroniser
		logic       tg1;                  // device reset toggle sync
		logic       tg2;                  // device reset toggle sync
		logic       tg3;                  // delayed copy, edge detect
		logic [7:0] byt;                  // last byte received, code or parameter
		logic       pend;                 // parameter awaits ack edge
		logic       ack;                  // acknowledge decision
		bridge_cfg_pkg::read_ptr_t ptr;   // read pointer
		logic [2:0] idx;                  // port config read slot
		logic [3:0] cfg;                  // device configuration
		logic       rflag;                // device-reset status flag
		logic [31:0] par;                 // port parameter codes
		logic [7:0] rdb;                  // byte offered to the host
	} link_st_t;

	// bus-side state, clocked by clk
	typedef struct packed {
		logic        ack;                 // wishbone acknowledge
		logic [31:0] dat;                 // read data
		logic        dev_tog;             // device reset request
		logic [3:0]  cfg;                 // settings copy
		logic        rflag;               // reset flag copy
		logic [1:0]  ptr;                 // read pointer copy
		logic [31:0] par;                 // parameter copy
	} bus_st_t;

	link_st_t ls;
	link_st_t ln;
	bus_st_t  cs;
	bus_st_t  cn;

	snap_if #(.W(bridge_cfg_pkg::SNAP_W)) snap ();

	// map selector and flag onto a storage slot; 101..111 are invalid
	function automatic logic [3:0] slot_of(input logic [2:0] sel,
			input logic od);
		logic [3:0] r;
		r = 4'h8;
		case (sel)
			bridge_cfg_pkg::SEL_RSTL,
			bridge_cfg_pkg::SEL_MSP,
			bridge_cfg_pkg::SEL_W0L: begin
				r = {1'b0, sel[1:0], od};
			end
			bridge_cfg_pkg::SEL_REC: begin
				r = {1'b0, bridge_cfg_pkg::SLOT_REC};
			end
			bridge_cfg_pkg::SEL_RWPU: begin
				r = {1'b0, bridge_cfg_pkg::SLOT_RWPU};
			end
			default: begin
				r = 4'h8;
			end
		endcase
		return r;
	endfunction

	// pick one four-bit code out of the parameter word
	function automatic logic [3:0] nib_at(input logic [31:0] p,
			input logic [2:0] i);
		return p[{i, 2'b00} +: bridge_cfg_pkg::PARAM_W];
	endfunction

	// byte the host would read at the given pointer
	function automatic logic [7:0] read_mux(
			input bridge_cfg_pkg::read_ptr_t p,
			input logic [3:0] cfg, input logic rflag,
			input logic busy, input logic [31:0] par,
			input logic [2:0] i);
		logic [7:0] r;
		r = 8'h00;
		case (p)
			bridge_cfg_pkg::PTR_STATUS: begin
				r = {6'h00, busy, rflag};
			end
			bridge_cfg_pkg::PTR_DEVCFG: begin
				r = {4'h0, cfg};
			end
			bridge_cfg_pkg::PTR_PORTCFG: begin
				r = {4'h0, nib_at(par, i)};
			end
			default: begin
				r = 8'h00;
			end
		endcase
		return r;
	endfunction

	// command decoding on the link clock
	always_comb begin
		logic [3:0] slot;
		slot = 4'h8;
		ln = ls;
		ln.por1 = rst_n;
		ln.por2 = ls.por1;
		ln.busy1 = bus_busy_flag;
		ln.busy2 = ls.busy1;
		ln.tg1 = cs.dev_tog;
		ln.tg2 = ls.tg1;
		ln.tg3 = ls.tg2;
		if (!ls.por2 || (ls.tg2 != ls.tg3)) begin
			ln.st = bridge_cfg_pkg::CMD_IDLE;
			ln.pend = 1'b0;
			ln.ack = 1'b0;
			ln.ptr = bridge_cfg_pkg::PTR_STATUS;
			ln.idx = 3'h0;
			ln.cfg = bridge_cfg_pkg::CFG_RESET;
			ln.rflag = bridge_cfg_pkg::RSTFLAG_RESET;
			ln.par = PARAM_DEFAULTS;
		end else if (frame_start) begin
			// a new transfer always begins with a command code
			ln.st = bridge_cfg_pkg::CMD_IDLE;
			ln.pend = 1'b0;
			ln.ack = 1'b0;
		end else begin
			if (byte_valid) begin
				ln.byt = byte_data;
				ln.pend = 1'b0;
				ln.ack = 1'b0;
				case (ls.st)
					bridge_cfg_pkg::CMD_IDLE: begin
						ln.st = bridge_cfg_pkg::CMD_IGNORE;
						if (byte_data == bridge_cfg_pkg::CMD_WRITE_CONFIG &&
								!ls.busy2) begin
							ln.st = bridge_cfg_pkg::CMD_CFG_PARAM;
							ln.ack = 1'b1;
						end
						if (byte_data == bridge_cfg_pkg::CMD_ADJUST_PORT &&
								!ls.busy2) begin
							ln.st = bridge_cfg_pkg::CMD_ADJ_PARAM;
							ln.ack = 1'b1;
						end
					end
					bridge_cfg_pkg::CMD_CFG_PARAM,
					bridge_cfg_pkg::CMD_ADJ_PARAM: begin
						ln.ack = 1'b1;
						ln.pend = 1'b1;
					end
					bridge_cfg_pkg::CMD_IGNORE: begin
						ln.ack = 1'b0;
					end
					default: begin
						ln.st = bridge_cfg_pkg::CMD_IDLE;
					end
				endcase
			end
			// the update lands on the ack bit's rising clock edge
			if (ack_edge && ls.pend) begin
				ln.pend = 1'b0;
				ln.st = bridge_cfg_pkg::CMD_IDLE;
				ln.idx = 3'h0;
				if (ls.st == bridge_cfg_pkg::CMD_CFG_PARAM) begin
					if (ls.byt[7:4] == ~ls.byt[3:0]) begin
						ln.cfg = ls.byt[3:0];
						ln.rflag = 1'b0;
					end
					ln.ptr = bridge_cfg_pkg::PTR_DEVCFG;
				end else begin
					slot = slot_of(
						ls.byt[bridge_cfg_pkg::SEL_MSB:bridge_cfg_pkg::SEL_LSB],
						ls.byt[bridge_cfg_pkg::OD_BIT]);
					if (!slot[3]) begin
						ln.par[{slot[2:0], 2'b00} +: bridge_cfg_pkg::PARAM_W] =
							ls.byt[bridge_cfg_pkg::CODE_MSB:0];
					end
					ln.ptr = bridge_cfg_pkg::PTR_PORTCFG;
				end
			end else if (byte_read &&
					ls.ptr == bridge_cfg_pkg::PTR_PORTCFG) begin
				// eight slots in order, wrapping back to the first
				ln.idx = ls.idx + 3'h1;
			end
		end
		ln.rdb = read_mux(ln.ptr, ln.cfg, ln.rflag, ls.busy2,
			ln.par, ln.idx);
	end

	// link registers; the reset synchroniser itself is never reset
	always_ff @(posedge link_clk) begin
		ls <= ln;
	end

	// settings word handed to the bus clock
	assign snap.src_word = {ls.ptr, ls.rflag, ls.cfg, ls.par};

	snap_cross #(
		.W (bridge_cfg_pkg::SNAP_W)
	) u_snap (
		.clk        (clk),
		.rst_n      (rst_n),
		.link_clk   (link_clk),
		.link_rst_n (ls.por2),
		.xf         (snap)
	);

	// wishbone slave and bus-side copies of the settings
	always_comb begin
		cn = cs;
		cn.ack = 1'b0;
		// a fresh snapshot refreshes every copy at once
		if (snap.dst_fresh) begin
			cn.par = snap.dst_word[31:0];
			cn.cfg = snap.dst_word[35:32];
			cn.rflag = snap.dst_word[36];
			cn.ptr = snap.dst_word[38:37];
		end
		// one wait state; ack drops the cycle after it is given
		if (wb_cyc_i && wb_stb_i && !cs.ack) begin
			cn.ack = 1'b1;
			cn.dat = 32'h0000_0000;
			case ({wb_adr_i[7:2], 2'b00})
				bridge_cfg_pkg::ADDR_CTRL: begin
					// self-clearing: the request is a toggle edge
					if (wb_we_i && wb_sel_i[0] &&
							wb_dat_i[bridge_cfg_pkg::CTRL_DEVRST_BIT]) begin
						cn.dev_tog = ~cs.dev_tog;
					end
				end
				bridge_cfg_pkg::ADDR_STATUS: begin
					if (!wb_we_i) begin
						cn.dat[bridge_cfg_pkg::ST_RSTFLAG_BIT] = cs.rflag;
						cn.dat[bridge_cfg_pkg::ST_BUSY_BIT] = bus_busy_flag;
						cn.dat[bridge_cfg_pkg::ST_PTR_LSB +: 2] = cs.ptr;
					end
				end
				bridge_cfg_pkg::ADDR_DEVCFG: begin
					if (!wb_we_i) begin
						cn.dat[3:0] = cs.cfg;
					end
				end
				bridge_cfg_pkg::ADDR_PORTCFG: begin
					if (!wb_we_i) begin
						cn.dat = cs.par;
					end
				end
				// unmapped: acknowledged, reads zero, writes dropped
				default: begin
					cn.dat = 32'h0000_0000;
				end
			endcase
		end
	end

	// bus registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs.ack <= 1'b0;
			cs.dat <= 32'h0000_0000;
			cs.dev_tog <= 1'b0;
			cs.cfg <= bridge_cfg_pkg::CFG_RESET;
			cs.rflag <= bridge_cfg_pkg::RSTFLAG_RESET;
			cs.ptr <= 2'h0;
			cs.par <= PARAM_DEFAULTS;
		end else begin
			cs <= cn;
		end
	end

	// outputs straight from flops
	assign wb_ack_o = cs.ack;
	assign wb_dat_o = cs.dat;
	assign overdrive_speed_select = cs.cfg[bridge_cfg_pkg::CFG_OWS_BIT];
	assign strong_pullup_enable   = cs.cfg[bridge_cfg_pkg::CFG_SPU_BIT];
	assign port_power_down        = cs.cfg[bridge_cfg_pkg::CFG_PDN_BIT];
	assign active_pullup_enable   = cs.cfg[bridge_cfg_pkg::CFG_APU_BIT];
	assign port_params = cs.par;
	assign ack_drive = ls.ack;
	assign read_ptr  = ls.ptr;
	assign read_byte = ls.rdb;
endmodule
`default_nettype wire

/* testbench/bridge_cfg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the bus and link ports of the command decoder
module bridge_cfg_monitor #(
	parameter logic [31:0] PARAM_DEFAULTS = 32'h6666_6666
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        overdrive_speed_select,
	input wire logic [31:0] port_params,
	input wire logic        link_clk,
	input wire logic        byte_valid,
	input wire logic        ack_edge,
	input wire logic        ack_drive,
	input wire logic [1:0]  read_ptr
);
	// bus answers: one cycle after the take, one cycle long
	property p_ack_one;
		@(posedge clk) disable iff (!rst_n) wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("bus ack longer than one cycle");
	property p_ack_resp;
		@(posedge clk) disable iff (!rst_n)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp)
		else $error("bus request not answered in one cycle");
	property p_ack_req;
		@(posedge clk) disable iff (!rst_n)
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_req: assert property (p_ack_req)
		else $error("bus ack without request");
	// defaults must be in place as reset lifts
	property p_rst_vals;
		@(posedge clk) disable iff (!rst_n) $rose(rst_n) |->
		port_params == PARAM_DEFAULTS && !overdrive_speed_select;
	endproperty
	a_rst_vals: assert property (p_rst_vals)
		else $error("reset values wrong");
	property p_cfg_upper;
		@(posedge clk) disable iff (!rst_n) wb_ack_o && !wb_we_i &&
		wb_adr_i == bridge_cfg_pkg::ADDR_DEVCFG |-> wb_dat_o[31:4] == 28'h0;
	endproperty
	a_cfg_upper: assert property (p_cfg_upper)
		else $error("config upper nibble not zero");
	property p_unmapped;
		@(posedge clk) disable iff (!rst_n)
		wb_ack_o && !wb_we_i && wb_adr_i > 8'h0C |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	// pointer moves off status only right after an ack bit edge
	property p_ptr_when;
		@(posedge link_clk) disable iff (!rst_n)
		$changed(read_ptr) && read_ptr != 2'h0 |-> $past(ack_edge);
	endproperty
	a_ptr_when: assert property (p_ptr_when)
		else $error("read pointer moved off the ack edge");
	property p_ptr_val;
		@(posedge link_clk) disable iff (!rst_n)
		$past(ack_edge) && $changed(read_ptr) |-> read_ptr inside {2'h2, 2'h3};
	endproperty
	a_ptr_val: assert property (p_ptr_val)
		else $error("read pointer moved to wrong place");
	property p_ack_rise;
		@(posedge link_clk) disable iff (!rst_n)
		$rose(ack_drive) |-> $past(byte_valid);
	endproperty
	a_ack_rise: assert property (p_ack_rise)
		else $error("acknowledge without a byte");
	// main scenarios reached
	c_cfg: cover property (@(posedge link_clk)
		$past(ack_edge) && read_ptr == 2'h2);
	c_adj: cover property (@(posedge link_clk)
		$past(ack_edge) && read_ptr == 2'h3);
	c_nak: cover property (@(posedge link_clk) $past(byte_valid) && !ack_drive);
endmodule
bind bridge_config_commands bridge_cfg_monitor #(
	.PARAM_DEFAULTS(PARAM_DEFAULTS)
) u_mon (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .overdrive_speed_select, .port_params, .link_clk,
	.byte_valid, .ack_edge, .ack_drive, .read_ptr);
`default_nettype wire

/* testbench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// serial host: clocks the link only while it has work to do
module host_model (
	output logic       link_clk,
	output logic       frame_start,
	output logic       byte_valid,
	output logic [7:0] byte_data,
	output logic       ack_edge,
	output logic       byte_read,
	input  wire logic  ack_drive
);
	logic run = 1'b1; // clock gate, parks low when idle
	// 48 ns period, odd start offset keeps it apart from the bus clock
	initial begin
		link_clk = 1'b0;
		#7;
		forever begin
			#24;
			if (run || link_clk) link_clk = ~link_clk;
		end
	end
	initial begin
		{frame_start, byte_valid, ack_edge, byte_read} = 4'h0;
		byte_data = 8'h00;
	end
	task automatic tick(input int n);
		run = 1'b1;
		repeat (n) @(posedge link_clk);
	endtask
	// trailing cycles let the settings cross before the clock stops
	task automatic halt;
		tick(16);
		run = 1'b0;
	endtask
	// one byte, then its ack bit; the answer is taken before the ack
	task automatic put(input logic [7:0] b, output logic a);
		byte_data <= b;
		byte_valid <= 1'b1;
		@(posedge link_clk) byte_valid <= 1'b0;
		repeat (2) @(posedge link_clk);
		a = ack_drive;
		ack_edge <= 1'b1;
		@(posedge link_clk) ack_edge <= 1'b0;
		@(posedge link_clk);
	endtask
	// code byte then one parameter byte
	task automatic send(input logic [7:0] c, p, output logic a0, a1);
		tick(4);
		frame_start <= 1'b1;
		@(posedge link_clk) frame_start <= 1'b0;
		put(c, a0);
		put(p, a1);
		halt();
	endtask
	task automatic rd;
		tick(1);
		byte_read <= 1'b1;
		@(posedge link_clk) byte_read <= 1'b0;
		tick(3);
		run = 1'b0;
	endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [31:0] DEF = 32'h6666_6666; // arbitrary defaults
	logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, bus_busy_flag;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i = 4'hF; // whole words only
	logic [31:0] wb_dat_i, wb_dat_o, port_params;
	logic        wb_ack_o, overdrive_speed_select, strong_pullup_enable;
	logic        port_power_down, active_pullup_enable, link_clk;
	logic        frame_start, byte_valid, ack_edge, byte_read, ack_drive;
	logic [7:0]  byte_data, read_byte;
	logic [1:0]  read_ptr;
	int          error_cnt = 0, n_compared = 0;
	int          cfg = 0, rflag = 1, ptr = 0, par[8]; // reference model
	bridge_config_commands #(.PARAM_DEFAULTS(DEF)) u_dut (.clk, .rst_n,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .bus_busy_flag, .overdrive_speed_select,
		.strong_pullup_enable, .port_power_down, .active_pullup_enable,
		.port_params, .link_clk, .frame_start, .byte_valid, .byte_data,
		.ack_edge, .byte_read, .ack_drive, .read_ptr, .read_byte);
	host_model u_host (.link_clk, .frame_start, .byte_valid, .byte_data,
		.ack_edge, .byte_read, .ack_drive);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic report_and_stop;
		if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	// classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int t;
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		if (t >= 50) begin
			chk("wb_ack", 1, 0);
			report_and_stop();
		end
	endtask
	function automatic logic [31:0] pw;
		for (int i = 0; i < 8; i++) pw[4*i+:4] = par[i][3:0];
	endfunction
	// compare every bus copy, output and the pointer with the model; read_byte only at config and port config
	task automatic verify;
		logic [31:0] q;
		wb(0, bridge_cfg_pkg::ADDR_STATUS, 0, q);
		chk("status", {ptr[1:0], 2'h0, bus_busy_flag, rflag[0]}, q);
		wb(0, bridge_cfg_pkg::ADDR_DEVCFG, 0, q);
		chk("devcfg", cfg, q);
		wb(0, bridge_cfg_pkg::ADDR_PORTCFG, 0, q);
		chk("portcfg", pw(), q);
		chk("settings", cfg, {overdrive_speed_select, strong_pullup_enable,
			port_power_down, active_pullup_enable});
		chk("params", pw(), port_params);
		chk("read_ptr", ptr, read_ptr);
		if (ptr == 2) chk("read_byte", cfg, read_byte);
		if (ptr == 3) chk("read_byte", par[0], read_byte);
	endtask
	task automatic cmd(input logic [7:0] c, p, input logic e);
		logic a0, a1;
		u_host.send(c, p, a0, a1);
		chk("ack_code", e, a0);
		chk("ack_param", e, a1);
	endtask
	initial begin
		#200000;
		chk("timeout", 0, 1);
		report_and_stop();
	end
	initial begin
		logic [31:0] q;
		logic [3:0]  v;
		int          sl;
		int          rdq[$];
		void'($urandom(32'hB08570A4));
		{wb_cyc_i, wb_stb_i, wb_we_i, bus_busy_flag} = 4'h0;
		{wb_adr_i, wb_dat_i, rst_n} = 0;
		for (int i = 0; i < 8; i++) par[i] = DEF[4*i+:4];
		// link side needs several of its own edges inside reset
		repeat (12) @(posedge link_clk);
		@(posedge clk) rst_n <= 1'b1;
		u_host.halt();
		verify();
		// commands below sent with the bus idle, bar the two sent while busy
		// a broken complement first: flag and settings must survive
		v = $urandom;
		cmd(8'hD2, {~v ^ (4'h1 << $urandom_range(3)), v}, 1);
		ptr = 2;
		verify();
		repeat (4) begin
			v = $urandom;
			cmd(8'hD2, {~v, v}, 1);
			cfg = v;
			rflag = 0;
			ptr = 2;
			verify();
		end
		for (int s = 0; s < 6; s++) for (int o = 0; o < 2; o++) begin
			v = $urandom;
			cmd(8'hC3, {s[2:0], o[0], v}, 1);
			sl = s < 3 ? 2 * s + o : (s == 3 ? 6 : (s == 4 ? 7 : -1));
			if (sl >= 0) par[sl] = v;
			ptr = 3;
			verify();
		end
		// readback order: slots in turn, then back to the first
		for (int k = 1; k < 9; k++) rdq.push_back(par[k % 8]);
		repeat (8) begin
			u_host.rd();
			chk("read_slot", rdq.pop_front(), read_byte);
		end
		// a good write must pull the pointer back from port config
		cmd(8'hD2, 8'h69, 1);
		cfg = 9;
		ptr = 2;
		verify();
		@(posedge clk) bus_busy_flag <= 1'b1;
		cmd(8'hD2, 8'h5A, 0);
		cmd(8'hC3, 8'h0F, 0);
		verify();
		@(posedge clk) bus_busy_flag <= 1'b0;
		// an unknown code is refused and its byte never stored
		cmd(8'h3C, 8'h96, 0);
		verify();
		wb(1, 8'h10, $urandom, q);
		wb(0, 8'h10, 0, q);
		chk("unmapped", 0, q);
		wb(1, bridge_cfg_pkg::ADDR_DEVCFG, 32'h0000_00FF, q);
		wb(1, bridge_cfg_pkg::ADDR_CTRL, 32'h0000_0001, q);
		u_host.halt();
		repeat (100) @(posedge clk);
		for (int i = 0; i < 8; i++) par[i] = DEF[4*i+:4];
		{cfg, rflag, ptr} = {32'd0, 32'd1, 32'd0};
		verify();
		report_and_stop();
	end
endmodule
`default_nettype wire
